// ---- uart_rx_pkg.sv ----
// Operation
// - The low fifteen bits of the period register form the bit-rate divider used for receive and transmit.
// - A divider value N gives exactly N+1 colour-clock ticks between receive samples and transmit bits.
// - All bit timing comes from a colour-clock tick of 279.36 ns (NTSC) or 281.94 ns (PAL).
// - Rates from 110 to beyond one million bits per second and lengths of eight or nine bits are supported.
// - Bit 15 of the write-only period register selects nine data bits when 1 and eight when 0.
// - Received characters appear in a 16-bit word that joins data bits with receive and transmit status bits.
// - Bits shift into an internal register and after the set bit count are copied out with data-ready raised.
// - Right after each copy the shift register accepts the next character with no dead time.
// - A character completing while the full flag is still set raises the overrun flag.
// - Status and interrupts exist for receive full and transmit empty, plus a transmit-shifter-empty flag.
// - Word bits 15..11 report overrun, receive full, transmit empty, shifter empty and the live pin level.
// - Bits 7..0 hold data true, bit 8 the stop or ninth bit, bit 9 the stop bit in nine-bit mode.
package uart_rx_pkg;

   // Byte addresses
   localparam logic [4:0] ADR_PERIOD = 5'h00;
   localparam logic [4:0] ADR_RXWORD = 5'h04;
   localparam logic [4:0] ADR_STATUS = 5'h08;
   localparam logic [4:0] ADR_MASK   = 5'h0C;
   localparam logic [4:0] ADR_TIMING = 5'h10;

   // Period register fields
   localparam int        PER_MODE_BIT = 15;
   localparam int        DIV_W        = 15;
   localparam logic [15:0] PERIOD_RST = 16'h0000;

   // Receive word fields
   localparam int WORD_OVR  = 15;
   localparam int WORD_RBF  = 14;
   localparam int WORD_TBE  = 13;
   localparam int WORD_TRANSMIT_SHIFTER_EMPTY_FLAG = 12;
   localparam int WORD_RXD  = 11;

   // Interrupt status / mask bits
   localparam int        IRQ_W    = 3;
   localparam int        IRQ_RBF  = 0;
   localparam int        IRQ_OVR  = 1;
   localparam int        IRQ_TBE  = 2;
   localparam logic [2:0] MASK_RST = 3'h0;

   // Colour clock and system clock, in picoseconds
   localparam int CLK_PERIOD_PS = 10000;
   localparam int CCK_NTSC_PS   = 279360;
   localparam int CCK_PAL_PS    = 281940;
   localparam int CCK_ACC_W     = 19;
   // Shortest and longest system cycles between colour ticks
   localparam int CCK_MIN_CYC   = CCK_NTSC_PS / CLK_PERIOD_PS;
   localparam int CCK_MAX_CYC   = (CCK_PAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Bit index of the stop bit in each mode
   localparam logic [3:0] STOP_IDX_8 = 4'h8;
   localparam logic [3:0] STOP_IDX_9 = 4'h9;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b10
   } rx_state_t;

endpackage

// ---- serial_uart_baud_receive.sv ----
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module serial_uart_baud_receive
   import uart_rx_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Serial line
   input  wire logic        rxd_i,
   // Transmit path link
   input  wire logic        tx_buffer_empty_i,
   input  wire logic        tx_shifter_empty_i,
   output logic             tx_bit_tick_o,
   // Interrupt
   output logic             irq_o
);

   logic [15:0]          period_r;
   logic                 pal_r;
   logic [IRQ_W-1:0]     stat_r;
   logic [IRQ_W-1:0]     mask_r;
   logic [CCK_ACC_W-1:0] cck_acc_r;
   logic                 cck_tick_r;
   logic [DIV_W-1:0]     tx_cnt_r;
   logic                 rx_s1_r;
   logic                 rx_s2_r;
   rx_state_t            st_r;
   logic [DIV_W-1:0]     rx_cnt_r;
   logic [3:0]           bit_idx_r;
   logic [9:0]           rx_shift_r;
   logic                 rx_done_r;
   logic [9:0]           rx_data_r;
   logic                 tbe_d_r;
   logic                 acc_req;
   logic                 wr_en;
   logic                 rd_en;
   logic [DIV_W-1:0]     divider;
   logic                 nine_bits;
   logic [3:0]           stop_idx;
   logic [15:0]          rx_word;
   logic [IRQ_W-1:0]     stat_set;
   logic [IRQ_W-1:0]     stat_clr;
   logic [CCK_ACC_W-1:0] cck_per;
   logic [CCK_ACC_W-1:0] cck_sum;

   assign divider   = period_r[DIV_W-1:0];
   assign nine_bits = period_r[PER_MODE_BIT];
   assign stop_idx  = nine_bits ? STOP_IDX_9 : STOP_IDX_8;

   // Bus handshake: one wait state, ack drops the cycle after it was given
   assign acc_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en   = acc_req & wb_we_i;
   assign rd_en   = acc_req & ~wb_we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= acc_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd_en) begin
         unique case (wb_adr_i)
            ADR_RXWORD: wb_dat_o <= {16'h0000, rx_word};
            ADR_STATUS: wb_dat_o <= {29'h0000_0000, stat_r};
            ADR_MASK:   wb_dat_o <= {29'h0000_0000, mask_r};
            ADR_TIMING: wb_dat_o <= {31'h0000_0000, pal_r};
            default:    wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // Period register is write-only; reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         period_r <= PERIOD_RST;
      end else if (wr_en && wb_adr_i == ADR_PERIOD) begin
         if (wb_sel_i[0]) begin
            period_r[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            period_r[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_r <= MASK_RST;
         pal_r  <= 1'b0;
      end else if (wr_en && wb_sel_i[0]) begin
         if (wb_adr_i == ADR_MASK) begin
            mask_r <= wb_dat_i[IRQ_W-1:0];
         end
         if (wb_adr_i == ADR_TIMING) begin
            pal_r <= wb_dat_i[0];
         end
      end
   end

   // Colour-clock tick from a picosecond phase accumulator
   assign cck_per = pal_r ? CCK_ACC_W'(CCK_PAL_PS) : CCK_ACC_W'(CCK_NTSC_PS);
   assign cck_sum = cck_acc_r + CCK_ACC_W'(CLK_PERIOD_PS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cck_acc_r  <= '0;
         cck_tick_r <= 1'b0;
      end else if (cck_sum >= cck_per) begin
         cck_acc_r  <= cck_sum - cck_per;
         cck_tick_r <= 1'b1;
      end else begin
         cck_acc_r  <= cck_sum;
         cck_tick_r <= 1'b0;
      end
   end

   // Transmit bit pacing: one pulse every divider+1 colour ticks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_cnt_r      <= '0;
         tx_bit_tick_o <= 1'b0;
      end else begin
         tx_bit_tick_o <= 1'b0;
         if (cck_tick_r) begin
            if (tx_cnt_r == '0) begin
               tx_cnt_r      <= divider;
               tx_bit_tick_o <= 1'b1;
            end else begin
               tx_cnt_r <= tx_cnt_r - 1'b1;
            end
         end
      end
   end

   // Receive pin synchroniser
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= rxd_i;
         rx_s2_r <= rx_s1_r;
      end
   end

   // Receive sequencer; start is checked at mid-bit, then divider+1 ticks per bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r       <= ST_IDLE;
         rx_cnt_r   <= '0;
         bit_idx_r  <= 4'h0;
         rx_shift_r <= 10'h000;
         rx_done_r  <= 1'b0;
      end else begin
         rx_done_r <= 1'b0;
         unique case (st_r)
            ST_IDLE: begin
               if (!rx_s2_r) begin
                  st_r     <= ST_START;
                  rx_cnt_r <= divider >> 1;
               end
            end
            ST_START: begin
               if (cck_tick_r) begin
                  if (rx_cnt_r != '0) begin
                     rx_cnt_r <= rx_cnt_r - 1'b1;
                  end else if (rx_s2_r) begin
                     st_r <= ST_IDLE;
                  end else begin
                     st_r       <= ST_DATA;
                     rx_cnt_r   <= divider;
                     bit_idx_r  <= 4'h0;
                     rx_shift_r <= 10'h000;
                  end
               end
            end
            ST_DATA: begin
               if (cck_tick_r) begin
                  if (rx_cnt_r != '0) begin
                     rx_cnt_r <= rx_cnt_r - 1'b1;
                  end else begin
                     rx_cnt_r              <= divider;
                     rx_shift_r[bit_idx_r] <= rx_s2_r;
                     bit_idx_r             <= bit_idx_r + 1'b1;
                     if (bit_idx_r == stop_idx) begin
                        rx_done_r <= 1'b1;
                        st_r      <= ST_IDLE;
                     end
                  end
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // Transfer to the receive word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_data_r <= 10'h000;
      end else if (rx_done_r) begin
         rx_data_r <= nine_bits ? rx_shift_r : {1'b0, rx_shift_r[8:0]};
      end
   end

   // Sticky status, cleared by reading it; a new event wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tbe_d_r <= 1'b1;
      end else begin
         tbe_d_r <= tx_buffer_empty_i;
      end
   end

   always_comb begin
      stat_set          = '0;
      stat_set[IRQ_RBF] = rx_done_r;
      stat_set[IRQ_OVR] = rx_done_r & stat_r[IRQ_RBF];
      stat_set[IRQ_TBE] = tx_buffer_empty_i & ~tbe_d_r;
      stat_clr          = (rd_en && wb_adr_i == ADR_STATUS) ? stat_r : '0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_r <= '0;
      end else begin
         stat_r <= (stat_r & ~stat_clr) | stat_set;
      end
   end

   assign irq_o = |(stat_r & mask_r);

   always_comb begin
      rx_word            = {6'h00, rx_data_r};
      rx_word[WORD_OVR]  = stat_r[IRQ_OVR];
      rx_word[WORD_RBF]  = stat_r[IRQ_RBF];
      rx_word[WORD_TBE]  = tx_buffer_empty_i;
      rx_word[WORD_TRANSMIT_SHIFTER_EMPTY_FLAG] = tx_shifter_empty_i;
      rx_word[WORD_RXD]  = rx_s2_r;
   end

   // Checking helpers
   logic [7:0]       cyc_gap_r;
   logic [DIV_W:0]   cck_gap_r;
   logic             gap_ok_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cyc_gap_r <= 8'h00;
      end else if (cck_tick_r) begin
         cyc_gap_r <= 8'h01;
      end else if (cyc_gap_r != 8'hFF) begin
         cyc_gap_r <= cyc_gap_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || (wr_en && wb_adr_i == ADR_PERIOD)) begin
         cck_gap_r <= '0;
         gap_ok_r  <= 1'b0;
      end else if (tx_bit_tick_o) begin
         cck_gap_r <= (DIV_W+1)'(cck_tick_r);
         gap_ok_r  <= 1'b1;
      end else if (cck_tick_r) begin
         cck_gap_r <= cck_gap_r + 1'b1;
      end
   end

   a_cck_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
      cck_tick_r && cyc_gap_r != 8'h00 && cyc_gap_r != 8'hFF |->
         cyc_gap_r >= 8'(CCK_MIN_CYC) && cyc_gap_r <= 8'(CCK_MAX_CYC))
      else $error("colour tick spacing out of range");

   a_bit_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_bit_tick_o && gap_ok_r |-> cck_gap_r == {1'b0, divider} + 1'b1)
      else $error("bit interval differs from divider plus one");

   a_divider_load: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_en && wb_adr_i == ADR_PERIOD && wb_sel_i == 4'hF |=>
         divider == $past(wb_dat_i[14:0]) && nine_bits == $past(wb_dat_i[15]))
      else $error("period write not applied");

   a_sync_chain: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) && !$past(rst_i, 2) |-> rx_s2_r == $past(rxd_i, 2))
      else $error("receive pin not two-stage synchronised");

   a_char_length: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_done_r |-> bit_idx_r == stop_idx + 1'b1)
      else $error("wrong number of bits before transfer");

   a_full_raised: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_done_r |=> stat_r[IRQ_RBF] && rx_word[WORD_RBF])
      else $error("receive full not raised after transfer");

   a_data_copy: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_done_r |=> rx_data_r[8:0] == $past(rx_shift_r[8:0]) &&
         rx_data_r[9] == ($past(nine_bits) & $past(rx_shift_r[9])))
      else $error("receive word data mismatch");

   a_no_dead_time: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_done_r |-> st_r == ST_IDLE)
      else $error("receiver not ready after transfer");

   a_overrun_set: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_done_r && stat_r[IRQ_RBF] |=> stat_r[IRQ_OVR] && rx_word[WORD_OVR])
      else $error("overrun not flagged");

   a_tbe_event: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(tx_buffer_empty_i) |=> ##1 stat_r[IRQ_TBE])
      else $error("transmit empty event lost");

   a_pin_live: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_en && wb_adr_i == ADR_RXWORD |=> wb_dat_o[WORD_RXD] == $past(rx_s2_r))
      else $error("pin level not reported in word");

   a_word_status: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_en && wb_adr_i == ADR_RXWORD |=>
         wb_dat_o[WORD_OVR] == $past(stat_r[IRQ_OVR]) && wb_dat_o[WORD_RBF] == $past(stat_r[IRQ_RBF]) &&
         wb_dat_o[WORD_TBE] == $past(tx_buffer_empty_i) && wb_dat_o[WORD_TRANSMIT_SHIFTER_EMPTY_FLAG] == $past(tx_shifter_empty_i))
      else $error("receive word status bits misplaced");

   a_status_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_en && wb_adr_i == ADR_STATUS && !rx_done_r |=> !stat_r[IRQ_RBF] && !stat_r[IRQ_OVR])
      else $error("status not cleared by read");

   a_overrun_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      stat_r[IRQ_OVR] && !(rd_en && wb_adr_i == ADR_STATUS) |=> stat_r[IRQ_OVR])
      else $error("overrun flag lost before status read");

endmodule

// ---- serial_peer.sv ----
`timescale 1ns/1ps
module serial_peer #(
   parameter int CYC = 112
) (
   input  wire logic clk_i,
   output logic      rxd_o
);
   // Idle line sits at the mark level
   initial rxd_o = 1'b1;

   // One start bit, n data bits LSB first, one stop bit; the line is left at mark afterwards
   task automatic send(input logic [8:0] d, input int n);
      for (int i = 0; i < n + 2; i++) begin
         rxd_o <= (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : 1'b1;
         repeat (CYC) @(posedge clk_i);
      end
   endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import uart_rx_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [4:0]  wb_adr_i = 5'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        rxd;
   logic        transmit_buffer_empty_flag = 1'b1;
   logic        transmit_shifter_empty_flag = 1'b0;
   logic        tick;
   logic        irq_o;
   int          num_errors = 0;
   int          samples_checked = 0;

   always #5 clk_i = ~clk_i;

   serial_uart_baud_receive u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rxd_i(rxd), .tx_buffer_empty_i(transmit_buffer_empty_flag), .tx_shifter_empty_i(transmit_shifter_empty_flag),
      .tx_bit_tick_o(tick), .irq_o(irq_o));

   // Four colour ticks of about 27.936 clocks each at divider 3
   serial_peer #(.CYC(112)) u_peer (.clk_i(clk_i), .rxd_o(rxd));

   task automatic print_verdict;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb_xfer(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         print_verdict();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb_xfer(1'b0, a, 32'h0000_0000, q);
      check(q, exp);
   endtask

   // Waits up to lim cycles for the line to reach 1 and returns the cycles spent
   task automatic wait_hi(ref logic s, input int lim, output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (s !== 1'b1 && n < lim);
      if (n >= lim) begin
         num_errors++;
         print_verdict();
      end
   endtask

   // Spacing of bit-rate pulses must stay within lo..hi clocks
   task automatic measure(input int lo, input int hi);
      int n;
      wait_hi(tick, 400, n);
      wait_hi(tick, 400, n);
      wait_hi(tick, 400, n);
      check({31'h0000_0000, (n >= lo && n <= hi)}, 32'h0000_0001);
   endtask

   initial begin
      int n;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(ADR_PERIOD, 32'h0000_0000);
      rd(ADR_MASK, 32'h0000_0000);
      rd(5'h14, 32'h0000_0000);
      rd(ADR_STATUS, 32'h0000_0000);
      rd(ADR_RXWORD, 32'h0000_2800);
      wr(ADR_PERIOD, 32'h0000_0003);
      wr(ADR_MASK, 32'h0000_0001);
      rd(ADR_PERIOD, 32'h0000_0000);
      measure(108, 112);
      wr(ADR_TIMING, 32'h0000_0001);
      rd(ADR_TIMING, 32'h0000_0001);
      measure(112, 116);
      wr(ADR_TIMING, 32'h0000_0000);
      // Single eight-bit character
      u_peer.send(9'h0A5, 8);
      wait_hi(irq_o, 300, n);
      rd(ADR_RXWORD, 32'h0000_69A5);
      rd(ADR_STATUS, 32'h0000_0001);
      rd(ADR_RXWORD, 32'h0000_29A5);
      check({31'h0000_0000, irq_o}, 32'h0000_0000);
      // Two characters back to back, nothing read between them
      u_peer.send(9'h03C, 8);
      u_peer.send(9'h0C3, 8);
      rd(ADR_RXWORD, 32'h0000_E9C3);
      rd(ADR_STATUS, 32'h0000_0003);
      // Nine-bit mode: ninth bit in 8, stop in 9
      wr(ADR_PERIOD, 32'h0000_8003);
      u_peer.send(9'h13C, 9);
      rd(ADR_RXWORD, 32'h0000_6B3C);
      rd(ADR_STATUS, 32'h0000_0001);
      // Transmit-empty event, first masked, then unmasked
      wr(ADR_MASK, 32'h0000_0000);
      transmit_buffer_empty_flag  <= 1'b0;
      transmit_shifter_empty_flag <= 1'b1;
      repeat (2) @(posedge clk_i);
      transmit_buffer_empty_flag <= 1'b1;
      repeat (4) @(posedge clk_i);
      check({31'h0000_0000, irq_o}, 32'h0000_0000);
      wr(ADR_MASK, 32'h0000_0004);
      check({31'h0000_0000, irq_o}, 32'h0000_0001);
      rd(ADR_STATUS, 32'h0000_0004);
      rd(ADR_RXWORD, 32'h0000_3B3C);
      check({31'h0000_0000, irq_o}, 32'h0000_0000);
      print_verdict();
   end

   initial begin
      repeat (60000) @(posedge clk_i);
      num_errors++;
      print_verdict();
   end
endmodule
